//--- logic/sfpp_defines.svh
`ifndef SFPP_DEFINES_SVH
`define SFPP_DEFINES_SVH
// ----------------------------------------------------------------
// Flash commands and page geometry
// ----------------------------------------------------------------
`define SFPP_OP_PP 8'h02
`define SFPP_OP_RDSR 8'h05
`define SFPP_OP_WREN 8'h06
`define SFPP_PAGE_BYTES 256
// ----------------------------------------------------------------
// Device status byte layout
// ----------------------------------------------------------------
`define SFPP_SR_BUSY 0
`define SFPP_SR_WEL 1
`define SFPP_SR_BP_LSB 2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFPP_MCLK_MHZ 200
`define SFPP_T_PP_NS 100000
`define SFPP_PP_CYCLES ((`SFPP_T_PP_NS * `SFPP_MCLK_MHZ) / 1000)
`define SFPP_SCLK_HALF 8
// ----------------------------------------------------------------
// Controller registers, byte offsets on AHB-Lite
// ----------------------------------------------------------------
`define SFPP_REG_TX 8'h00
`define SFPP_REG_RX 8'h04
`define SFPP_REG_STAT 8'h08
`define SFPP_REG_IRQ_STATUS 8'h0C
`define SFPP_REG_IRQ_CLEAR 8'h10
`define SFPP_REG_IRQ_ENABLE 8'h14
`define SFPP_TX_LAST 8
`define SFPP_STAT_BUSY 0
`define SFPP_STAT_CS 1
`define SFPP_IRQ_BYTE 0
`define SFPP_IRQ_FRAME 1
`define SFPP_IRQ_SEQ 2
`define SFPP_IRQ_RESET 3'h0
`endif

//--- logic/sfpp_pkg.sv
package sfpp_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_OPC = 3'b001,
    PH_ADDR = 3'b010,
    PH_DATA = 3'b011,
    PH_STAT = 3'b100,
    PH_WREN = 3'b101,
    PH_SKIP = 3'b110
  } sfpp_phase_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_SHIFT = 3'b001,
    HS_HOLD = 3'b010,
    HS_END = 3'b011,
    HS_GAP = 3'b100
  } sfpp_hstate_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sclk_d;
    logic cs_n_d;
    sfpp_phase_t phase;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [23:0] addr;
    logic [1:0] abyte;
    logic has_data;
    logic [7:0] out_sh;
    logic so;
    logic so_oe_n;
    logic write_latch_flag;
    logic busy;
    logic [31:0] pp_cnt;
    logic [15:0] pg;
    logic [255:0] valid;
  } sfpp_dev_state_t;

  typedef struct packed {
    logic so_s1;
    logic so_s2;
    sfpp_hstate_t state;
    logic [7:0] cnt;
    logic ph;
    logic [2:0] bits;
    logic [7:0] tx_sh;
    logic last;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic sclk;
    logic cs_n;
    logic si;
    logic [2:0] irq_st;
    logic [2:0] irq_en;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic rd_done;
    logic [31:0] hrdata;
    logic we_seen;
    logic [7:0] frame_op;
    logic frame_multi;
  } sfpp_host_state_t;
endpackage

//--- logic/sfpp_if.sv
`timescale 1ns/1ps
interface sfpp_if;
  logic sclk;
  logic cs_n;
  logic si;
  logic so_drv;
  logic so_oe_n;
  logic so;

  // Released output line reads high, as with a pull-up
  assign so = so_oe_n ? 1'b1 : so_drv;

  modport device (input sclk, input cs_n, input si, output so_drv, output so_oe_n);
  modport host (output sclk, output cs_n, output si, input so);
endinterface

//--- logic/sfpp_flash_dev.sv
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "sfpp_defines.svh"
module sfpp_flash_dev #(
  parameter int MEM_PAGES = 4,
  parameter int PP_CYCLES = `SFPP_PP_CYCLES,
  localparam int AW = $clog2(MEM_PAGES) + 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Serial link
  sfpp_if.device link,
  // Protection setting and flags
  input wire logic [4:0] block_protect_bits_i,
  output logic program_busy_flag_o,
  output logic write_latch_flag_o,
  // Array read-back
  input wire logic [AW-1:0] mem_rd_addr_i,
  output logic [7:0] mem_rd_data_o
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (MEM_PAGES < 2 || MEM_PAGES > 65536 || (MEM_PAGES & (MEM_PAGES - 1)) != 0) begin : g_chk_pages
    $error("MEM_PAGES must be a power of two from 2 to 65536");
  end
  if (PP_CYCLES < `SFPP_PAGE_BYTES + 1) begin : g_chk_pp
    $error("PP_CYCLES must exceed the page size");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sfpp_pkg::sfpp_dev_state_t r_reg;
  sfpp_pkg::sfpp_dev_state_t r_next;
  logic [7:0] page_buf [`SFPP_PAGE_BYTES];
  // Array starts erased; contents survive reset like real flash cells
  logic [7:0] mem [MEM_PAGES * `SFPP_PAGE_BYTES] = '{default: 8'hFF};
  logic [7:0] mem_rd_q;
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] byte_in;
  logic [7:0] sr_byte;
  logic buf_we;
  logic [7:0] buf_idx;
  logic mem_we;
  logic [7:0] copy_idx;
  logic [AW-1:0] mem_wa;
  logic [31:0] prot_sum;
  logic page_prot;

  // Only the second synchroniser stage feeds logic
  assign cs_n_s = r_reg.sync2[2];
  assign sclk_s = r_reg.sync2[1];
  assign si_s = r_reg.sync2[0];
  assign sclk_rise = sclk_s & ~r_reg.sclk_d;
  assign sclk_fall = ~sclk_s & r_reg.sclk_d;
  assign cs_fall = ~cs_n_s & r_reg.cs_n_d;
  assign cs_rise = cs_n_s & ~r_reg.cs_n_d;
  assign byte_in = {r_reg.shreg[6:0], si_s};
  assign sr_byte = {1'b0, block_protect_bits_i, r_reg.write_latch_flag, r_reg.busy};
  assign copy_idx = r_reg.pp_cnt[7:0];
  assign mem_wa = {r_reg.pg[AW-9:0], copy_idx};
  // Top pages are guarded: a setting of n protects the last n pages
  assign prot_sum = {16'h0000, r_reg.addr[23:8] & 16'(MEM_PAGES - 1)}
                    + {27'h0000000, block_protect_bits_i};
  assign page_prot = (block_protect_bits_i != 5'h00) && (prot_sum >= 32'(MEM_PAGES));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    buf_we = 1'b0;
    buf_idx = r_reg.addr[7:0];
    mem_we = 1'b0;
    r_next.sync1 = {link.cs_n, link.sclk, link.si};
    r_next.sync2 = r_reg.sync1;
    r_next.sclk_d = sclk_s;
    r_next.cs_n_d = cs_n_s;

    if (cs_fall) begin
      r_next.phase = sfpp_pkg::PH_OPC;
      r_next.bitcnt = 3'h0;
      r_next.abyte = 2'h0;
      r_next.has_data = 1'b0;
    end else if (cs_rise) begin
      // Execute only on a whole byte with the latch set and page open
      if (r_reg.phase == sfpp_pkg::PH_DATA && r_reg.bitcnt == 3'h0
          && r_reg.has_data && r_reg.write_latch_flag && !page_prot) begin
        r_next.busy = 1'b1;
        r_next.pp_cnt = 32'h00000000;
        r_next.pg = r_reg.addr[23:8];
        r_next.write_latch_flag = 1'b0;
      end
      if (r_reg.phase == sfpp_pkg::PH_WREN && r_reg.bitcnt == 3'h0) begin
        r_next.write_latch_flag = 1'b1;
      end
      r_next.phase = sfpp_pkg::PH_IDLE;
      r_next.so_oe_n = 1'b1;
    end else if (!cs_n_s && sclk_rise) begin
      r_next.shreg = byte_in;
      r_next.bitcnt = 3'(r_reg.bitcnt + 3'h1);
      if (r_reg.phase == sfpp_pkg::PH_WREN) begin
        r_next.phase = sfpp_pkg::PH_SKIP;
      end
      if (r_reg.bitcnt == 3'h7) begin
        unique case (r_reg.phase)
          sfpp_pkg::PH_OPC: begin
            // While programming only status reads are accepted
            if (byte_in == `SFPP_OP_RDSR) begin
              r_next.phase = sfpp_pkg::PH_STAT;
              r_next.so_oe_n = 1'b0;
            end else if (r_reg.busy) begin
              r_next.phase = sfpp_pkg::PH_SKIP;
            end else if (byte_in == `SFPP_OP_PP) begin
              r_next.phase = sfpp_pkg::PH_ADDR;
              r_next.valid = '0;
            end else if (byte_in == `SFPP_OP_WREN) begin
              r_next.phase = sfpp_pkg::PH_WREN;
            end else begin
              r_next.phase = sfpp_pkg::PH_SKIP;
            end
          end
          sfpp_pkg::PH_ADDR: begin
            r_next.addr = {r_reg.addr[15:0], byte_in};
            r_next.abyte = 2'(r_reg.abyte + 2'h1);
            if (r_reg.abyte == 2'h2) begin
              r_next.phase = sfpp_pkg::PH_DATA;
            end
          end
          sfpp_pkg::PH_DATA: begin
            // Later bytes overwrite earlier ones at the same offset
            buf_we = 1'b1;
            r_next.valid[r_reg.addr[7:0]] = 1'b1;
            r_next.addr[7:0] = 8'(r_reg.addr[7:0] + 8'h01);
            r_next.has_data = 1'b1;
          end
          sfpp_pkg::PH_IDLE, sfpp_pkg::PH_STAT, sfpp_pkg::PH_WREN, sfpp_pkg::PH_SKIP: begin
          end
          default: begin
            r_next.phase = sfpp_pkg::PH_SKIP;
          end
        endcase
      end
    end else if (!cs_n_s && sclk_fall && r_reg.phase == sfpp_pkg::PH_STAT) begin
      // Status byte repeats while the host keeps clocking
      if (r_reg.bitcnt == 3'h0) begin
        r_next.so = sr_byte[7];
        r_next.out_sh = {sr_byte[6:0], 1'b0};
      end else begin
        r_next.so = r_reg.out_sh[7];
        r_next.out_sh = {r_reg.out_sh[6:0], 1'b0};
      end
    end

    // Self-timed cycle: copy the marked bytes, then run out the time
    if (r_reg.busy) begin
      r_next.pp_cnt = r_reg.pp_cnt + 32'h00000001;
      if (r_reg.pp_cnt < 32'(`SFPP_PAGE_BYTES)) begin
        mem_we = r_reg.valid[copy_idx];
      end
      if (r_reg.pp_cnt == 32'(PP_CYCLES - 1)) begin
        r_next.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Synchroniser idles at the line levels so no false edge follows reset
      r_reg <= '{sync1: 3'h4, sync2: 3'h4, cs_n_d: 1'b1, phase: sfpp_pkg::PH_IDLE,
                 so_oe_n: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Page buffer and array
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (buf_we) begin
      page_buf[buf_idx] <= byte_in;
    end
    if (mem_we) begin
      mem[mem_wa] <= page_buf[copy_idx];
    end
    mem_rd_q <= mem[mem_rd_addr_i];
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_rd_data_o <= 8'h00;
    end else begin
      mem_rd_data_o <= mem_rd_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.so_drv = r_reg.so;
  assign link.so_oe_n = r_reg.so_oe_n;
  assign program_busy_flag_o = r_reg.busy;
  assign write_latch_flag_o = r_reg.write_latch_flag;
endmodule // sfpp_flash_dev

//--- logic/sfpp_host_ctrl.sv
`timescale 1ns/1ps
`include "sfpp_defines.svh"
module sfpp_host_ctrl #(
  parameter int SCLK_HALF = `SFPP_SCLK_HALF
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Interrupt
  output logic irq_o,
  // Serial link
  sfpp_if.host link
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // The device needs about six cycles to turn its output round
  if (SCLK_HALF < 7 || SCLK_HALF > 255) begin : g_chk_half
    $error("SCLK_HALF must be 7 to 255");
  end

  sfpp_pkg::sfpp_host_state_t r_reg;
  sfpp_pkg::sfpp_host_state_t r_next;
  logic eng_ready;
  logic tx_stall;
  logic rd_stall;
  logic half_done;
  logic [2:0] ev;
  logic [31:0] rd_val;

  assign eng_ready = (r_reg.state == sfpp_pkg::HS_IDLE) || (r_reg.state == sfpp_pkg::HS_HOLD);
  assign tx_stall = r_reg.ap_valid && r_reg.ap_write && r_reg.ap_addr == `SFPP_REG_TX
                    && !eng_ready;
  assign rd_stall = r_reg.ap_valid && !r_reg.ap_write && !r_reg.rd_done;
  assign half_done = r_reg.cnt == 8'(SCLK_HALF - 1);

  always_comb begin
    unique case (r_reg.ap_addr)
      `SFPP_REG_RX: rd_val = {24'h000000, r_reg.rx_data};
      `SFPP_REG_STAT: rd_val = {30'h00000000, ~r_reg.cs_n, ~eng_ready};
      `SFPP_REG_IRQ_STATUS: rd_val = {29'h00000000, r_reg.irq_st};
      `SFPP_REG_IRQ_ENABLE: rd_val = {29'h00000000, r_reg.irq_en};
      default: rd_val = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    ev = 3'h0;
    r_next.so_s1 = link.so;
    r_next.so_s2 = r_reg.so_s1;

    // Bus: a read waits one cycle so it sees the previous write's effect
    if (rd_stall) begin
      r_next.hrdata = rd_val;
      r_next.rd_done = 1'b1;
    end
    if (r_reg.ap_valid && r_reg.ap_write && !tx_stall) begin
      if (r_reg.ap_addr == `SFPP_REG_TX) begin
        r_next.tx_sh = hwdata_i[7:0];
        r_next.last = hwdata_i[`SFPP_TX_LAST];
        r_next.si = hwdata_i[7];
        r_next.cs_n = 1'b0;
        r_next.state = sfpp_pkg::HS_SHIFT;
        r_next.cnt = 8'h00;
        r_next.ph = 1'b0;
        r_next.bits = 3'h0;
        if (r_reg.state == sfpp_pkg::HS_IDLE) begin
          r_next.frame_op = hwdata_i[7:0];
          r_next.frame_multi = 1'b0;
          // Program without a prior write enable is flagged, still sent
          if (hwdata_i[7:0] == `SFPP_OP_PP && !r_reg.we_seen) begin
            ev[`SFPP_IRQ_SEQ] = 1'b1;
          end
          if (hwdata_i[7:0] == `SFPP_OP_PP) begin
            r_next.we_seen = 1'b0;
          end
        end else begin
          r_next.frame_multi = 1'b1;
        end
      end else if (r_reg.ap_addr == `SFPP_REG_IRQ_ENABLE) begin
        r_next.irq_en = hwdata_i[2:0];
      end
    end
    if (hreadyout_o) begin
      r_next.ap_valid = hsel_i && htrans_i[1] && hready_i;
      r_next.ap_write = hwrite_i;
      r_next.ap_addr = haddr_i[7:0];
      r_next.rd_done = 1'b0;
    end

    // Serial engine, mode 0: sample on rise, shift on fall
    unique case (r_reg.state)
      sfpp_pkg::HS_IDLE, sfpp_pkg::HS_HOLD: begin
      end
      sfpp_pkg::HS_SHIFT: begin
        r_next.cnt = half_done ? 8'h00 : 8'(r_reg.cnt + 8'h01);
        if (half_done && !r_reg.ph) begin
          r_next.sclk = 1'b1;
          r_next.ph = 1'b1;
          r_next.rx_sh = {r_reg.rx_sh[6:0], r_reg.so_s2};
        end else if (half_done) begin
          r_next.sclk = 1'b0;
          r_next.ph = 1'b0;
          r_next.tx_sh = {r_reg.tx_sh[6:0], 1'b0};
          r_next.si = r_reg.tx_sh[6];
          r_next.bits = 3'(r_reg.bits + 3'h1);
          if (r_reg.bits == 3'h7) begin
            // Select may only be released on a byte boundary
            r_next.rx_data = r_reg.rx_sh;
            ev[`SFPP_IRQ_BYTE] = 1'b1;
            r_next.state = r_reg.last ? sfpp_pkg::HS_END : sfpp_pkg::HS_HOLD;
          end
        end
      end
      sfpp_pkg::HS_END: begin
        r_next.cnt = half_done ? 8'h00 : 8'(r_reg.cnt + 8'h01);
        if (half_done) begin
          r_next.cs_n = 1'b1;
          r_next.state = sfpp_pkg::HS_GAP;
          ev[`SFPP_IRQ_FRAME] = 1'b1;
          if (r_reg.frame_op == `SFPP_OP_WREN && !r_reg.frame_multi) begin
            r_next.we_seen = 1'b1;
          end
        end
      end
      sfpp_pkg::HS_GAP: begin
        r_next.cnt = half_done ? 8'h00 : 8'(r_reg.cnt + 8'h01);
        if (half_done) begin
          r_next.state = sfpp_pkg::HS_IDLE;
        end
      end
      default: begin
        r_next.state = sfpp_pkg::HS_IDLE;
      end
    endcase

    // Sticky events: a new event wins over a clear in the same cycle
    if (r_reg.ap_valid && r_reg.ap_write && r_reg.ap_addr == `SFPP_REG_IRQ_CLEAR) begin
      r_next.irq_st = r_reg.irq_st & ~hwdata_i[2:0];
    end
    r_next.irq_st = r_next.irq_st | ev;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_reg <= '{so_s1: 1'b1, so_s2: 1'b1, state: sfpp_pkg::HS_IDLE, cs_n: 1'b1,
                 irq_st: `SFPP_IRQ_RESET, irq_en: `SFPP_IRQ_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout_o = !(tx_stall || rd_stall);
  assign hresp_o = 1'b0;
  assign hrdata_o = r_reg.hrdata;
  assign irq_o = |(r_reg.irq_st & r_reg.irq_en);
  assign link.sclk = r_reg.sclk;
  assign link.cs_n = r_reg.cs_n;
  assign link.si = r_reg.si;
endmodule // sfpp_host_ctrl

//--- tb/sfpp_properties.sv
`timescale 1ns/1ps
module sfpp_properties #(
  parameter int PP_CYCLES = 300
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Link and device flags
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic so_oe_n,
  input wire logic program_busy_flag_o,
  input wire logic write_latch_flag_o
);
  logic [3:0] since_rise;
  logic [11:0] bits;
  logic [31:0] busy_cnt;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // ------------------------------------------------------------
  // Counters for spans too long to unroll
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      since_rise <= 4'h0;
      bits <= 12'h000;
      busy_cnt <= 32'h0;
    end else begin
      since_rise <= !cs_n ? 4'h0 : (since_rise == 4'hF ? since_rise : since_rise + 4'h1);
      bits <= cs_n ? 12'h000 : bits + {11'h000, $rose(sclk)};
      busy_cnt <= program_busy_flag_o ? busy_cnt + 32'h1 : 32'h0;
    end
  end

  property p_busy_launch;
    $rose(program_busy_flag_o) |-> cs_n && since_rise <= 4'h8;
  endproperty
  a_busy_launch: assert property (p_busy_launch) else $error("busy rose off release");
  property p_busy_needs_wel;
    $rose(program_busy_flag_o) |-> $past(write_latch_flag_o);
  endproperty
  a_busy_needs_wel: assert property (p_busy_needs_wel) else $error("ran without latch");
  property p_busy_len;
    $fell(program_busy_flag_o) |-> busy_cnt >= PP_CYCLES - 1 && busy_cnt <= PP_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy span wrong");
  property p_busy_hold;
    $rose(program_busy_flag_o) |=> program_busy_flag_o[*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_wel_clear;
    program_busy_flag_o |-> !write_latch_flag_o;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch set while programming");
  property p_so_release;
    $rose(cs_n) |-> ##[1:8] so_oe_n;
  endproperty
  a_so_release: assert property (p_so_release) else $error("output not released");
  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock active outside frame");
  property p_sclk_high;
    $rose(sclk) |-> sclk[*8] ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("clock high phase wrong");
  property p_cs_boundary;
    $rose(cs_n) |-> bits != 12'h000 && bits[2:0] == 3'h0;
  endproperty
  a_cs_boundary: assert property (p_cs_boundary) else $error("select released mid byte");

  c_busy_rise: cover property ($rose(program_busy_flag_o));
  c_busy_fall: cover property ($fell(program_busy_flag_o));
  c_frame_end: cover property ($rose(cs_n));
endmodule // sfpp_properties

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int PP = 2000;
  localparam logic [9:0] WOFF [5] = '{10'h1FE, 10'h1FF, 10'h100, 10'h101, 10'h102};
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, busy1, wel1, busy2, wel2;
  logic [31:0] hrdata, pval;
  logic [7:0] mem1, mem2;
  logic [4:0] bp = 5'h00;
  logic [9:0] ma = 10'h000;
  logic [2:0] psel = 3'h0;
  logic rd_ph = 1'b0;
  logic pv = 1'b0;
  logic [15:0] rnd = 16'h0010;
  logic [31:0] exp_q[$];
  logic [7:0] d[$];
  logic [7:0] f[$];
  int err_count = 0;
  int n_tests = 0;

  sfpp_if lk();
  sfpp_if lk2();

  sfpp_host_ctrl #(.SCLK_HALF(8)) sfpp_host_ctrl_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .hrdata_o(hrdata), .irq_o(irq), .link(lk.host));
  sfpp_flash_dev #(.MEM_PAGES(4), .PP_CYCLES(PP)) sfpp_flash_dev_i (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .link(lk.device), .block_protect_bits_i(bp),
    .program_busy_flag_o(busy1), .write_latch_flag_o(wel1), .mem_rd_addr_i(ma),
    .mem_rd_data_o(mem1));
  // Second end, fed by a bench driver that may break the framing
  sfpp_flash_dev #(.MEM_PAGES(4), .PP_CYCLES(PP)) sfpp_flash_dev_i2 (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .link(lk2.device), .block_protect_bits_i(5'h00),
    .program_busy_flag_o(busy2), .write_latch_flag_o(wel2), .mem_rd_addr_i(ma),
    .mem_rd_data_o(mem2));
  sfpp_properties #(.PP_CYCLES(PP)) sfpp_properties_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .sclk(lk.sclk), .cs_n(lk.cs_n), .so_oe_n(lk.so_oe_n), .program_busy_flag_o(busy1),
    .write_latch_flag_o(wel1));

  assign pval = psel == 3'h0 ? {24'h0, mem1} : psel == 3'h1 ? {24'h0, mem2} :
    psel == 3'h2 ? {30'h0, busy1, wel1} : psel == 3'h3 ? {30'h0, busy2, wel2} :
    {30'h0, hresp, irq};

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ------------------------------------------------------------
  // Compare and close
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task tally_and_finish();
    $display("mismatches=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    if (rd_ph && hreadyout) check(hrdata, exp_q.pop_front());
    if (pv) check(pval, exp_q.pop_front());
  end

  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Sampled at the falling edge so a combinational ready is settled
  task rdy();
    @(negedge mclk_i);
    while (!hreadyout) @(negedge mclk_i);
    @(posedge mclk_i);
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
    if (!w) exp_q.push_back(v);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    htrans <= 2'h0;
    hwdata <= w ? v : 32'h0;
    rd_ph <= !w;
    rdy();
    rd_ph <= 1'b0;
  endtask

  task frm(input logic [7:0] q[$]);
    foreach (q[i]) ahb(1'b1, 8'h00, {23'h0, i == q.size() - 1, q[i]});
    @(negedge mclk_i);
    while (!lk.cs_n) @(negedge mclk_i);
    repeat (10) @(posedge mclk_i);
  endtask

  task probe(input logic [2:0] s, input logic [9:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    psel <= s;
    ma <= a;
    repeat (3) @(posedge mclk_i);
    pv <= 1'b1;
    @(posedge mclk_i);
    pv <= 1'b0;
  endtask

  task bb(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      lk2.si = b[i];
      #32 lk2.sclk = 1'b1;
      #32 lk2.sclk = 1'b0;
    end
  endtask

  // Link clock of 64 ns, off the system clock's rising edges, still between frames
  task bbf(input logic [7:0] q[$], input int extra);
    #0.5 lk2.cs_n = 1'b0;
    foreach (q[i]) bb(q[i], 8);
    bb(8'h00, extra);
    #32 lk2.cs_n = 1'b1;
    lk2.si = ~lk2.si;
    repeat (10) @(posedge mclk_i);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    lk2.sclk = 1'b0;
    lk2.cs_n = 1'b1;
    lk2.si = 1'b0;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    probe(3'h2, 10'h000, 32'h0);
    ahb(1'b0, 8'h08, 32'h0);
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);
    frm('{8'h02, 8'h00, 8'h00, 8'h00, 8'h55});
    probe(3'h2, 10'h000, 32'h0);
    probe(3'h0, 10'h000, 32'hFF);
    ahb(1'b0, 8'h0C, 32'h7);
    probe(3'h4, 10'h000, 32'h0);
    ahb(1'b1, 8'h14, 32'h4);
    probe(3'h4, 10'h000, 32'h1);
    ahb(1'b1, 8'h10, 32'h7);
    ahb(1'b0, 8'h0C, 32'h0);
    probe(3'h4, 10'h000, 32'h0);
    bp <= 5'h01;
    frm('{8'h06});
    frm('{8'h02, 8'h00, 8'h03, 8'h00, 8'h66});
    probe(3'h2, 10'h000, 32'h1);
    probe(3'h0, 10'h300, 32'hFF);
    bp <= 5'h00;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      d.push_back(rnd[7:0]);
    end
    frm('{8'h02, 8'h00, 8'h01, 8'hFE, d[0], d[1], d[2], d[3]});
    probe(3'h2, 10'h000, 32'h2);
    frm('{8'h05, 8'h00});
    ahb(1'b0, 8'h04, 32'h01);
    repeat (PP) @(posedge mclk_i);
    probe(3'h2, 10'h000, 32'h0);
    foreach (WOFF[i]) probe(3'h0, WOFF[i], {24'h0, i < 4 ? d[i] : 8'hFF});
    bbf('{8'h06}, 0);
    bbf('{8'h02, 8'h00, 8'h02, 8'h00, 8'hA5}, 3);
    probe(3'h3, 10'h000, 32'h1);
    probe(3'h1, 10'h200, 32'hFF);
    d.delete();
    f = '{8'h02, 8'h00, 8'h00, 8'h10};
    for (int i = 0; i < 258; i++) begin
      rnd = lfsr(rnd);
      d.push_back(rnd[7:0]);
      f.push_back(rnd[7:0]);
    end
    bbf('{8'h06}, 0);
    bbf(f, 0);
    probe(3'h3, 10'h000, 32'h2);
    repeat (PP + 20) @(posedge mclk_i);
    probe(3'h3, 10'h000, 32'h0);
    probe(3'h1, 10'h00F, {24'h0, d[255]});
    probe(3'h1, 10'h010, {24'h0, d[256]});
    probe(3'h1, 10'h011, {24'h0, d[257]});
    probe(3'h1, 10'h012, {24'h0, d[2]});
    tally_and_finish();
  end
endmodule // tb
